// ### core/tief_pkg.sv
`default_nettype none
package tief_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_SET   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_FLAG         = 8'h2c;
   localparam logic [1:0]        ADDR_LSB_ZERO    = 2'h0;

   // Field positions, shared by enable and flag layouts
   localparam int BIT_OVERFLOW       = 0;
   localparam int BIT_RETRIGGER      = 1;
   localparam int BIT_COUNTER_EVENT  = 2;
   localparam int BIT_CAPTURE_ERROR  = 3;
   localparam int BIT_DEBUG_FAULT    = 11;
   localparam int BIT_RECOV_FAULT_A  = 12;
   localparam int BIT_RECOV_FAULT_B  = 13;
   localparam int BIT_NONREC_FAULT_0 = 14;
   localparam int BIT_NONREC_FAULT_1 = 15;
   localparam int MATCH_CAPTURE_LSB  = 16;
   localparam int MATCH_CAPTURE_N    = 4;

   // Implemented bits; 31:20 and 10:4 stay zero
   localparam logic [DATA_W-1:0] IMPL_MASK = 32'h000f_f80f;
   localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [DATA_W-1:0] w_data;
      logic [STRB_W-1:0] w_strb;
      logic              b_valid;
      logic [1:0]        b_resp;
      logic              r_valid;
      logic [DATA_W-1:0] r_data;
      logic [1:0]        r_resp;
   } tief_axi_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] enable;
   } tief_enable_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] flag;
   } tief_flag_state_t;

   // Word-aligned address compare
   function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      addr_is = ({addr[ADDR_W-1:2], ADDR_LSB_ZERO} == ofs);
   endfunction

   // Expand byte strobes to a bit mask
   function automatic logic [DATA_W-1:0] strb_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = ZERO_WORD;
      for (int i = 0; i < STRB_W; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      strb_mask = m;
   endfunction
endpackage
`default_nettype wire

// ### core/tief_reg_if.sv
`default_nettype none
interface tief_reg_if;
   logic                      enable_clear_wr;
   logic                      enable_set_wr;
   logic                      flag_clear_wr;
   logic [tief_pkg::DATA_W-1:0] wr_bits;
   logic [tief_pkg::DATA_W-1:0] enable_q;
   logic [tief_pkg::DATA_W-1:0] flag_q;

   modport bus   (output enable_clear_wr, enable_set_wr, flag_clear_wr, wr_bits, input enable_q, flag_q);
   modport enable(input enable_clear_wr, enable_set_wr, wr_bits, output enable_q);
   modport flags (input flag_clear_wr, wr_bits, output flag_q);
endinterface
`default_nettype wire

// ### core/tief_enable_bank.sv
`default_nettype none
module tief_enable_bank (
   input  wire logic core_clk,
   input  wire logic rst,
   tief_reg_if.enable regs
);
   tief_pkg::tief_enable_state_t state;
   tief_pkg::tief_enable_state_t next_state;

   // Shared enable state, set and clear by writing ones
   always_comb begin
      next_state = state;
      if (regs.enable_clear_wr) begin
         next_state.enable = state.enable & ~(regs.wr_bits & tief_pkg::IMPL_MASK);
      end
      if (regs.enable_set_wr) begin
         next_state.enable = state.enable | (regs.wr_bits & tief_pkg::IMPL_MASK);
      end
      if (rst) begin
         next_state.enable = tief_pkg::RESET_VAL;
      end
   end

   always_ff @(posedge core_clk) begin
      state <= next_state;
   end

   assign regs.enable_q = state.enable;

   a_enable_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
      (state.enable & ~tief_pkg::IMPL_MASK) == tief_pkg::ZERO_WORD)
      else $error("reserved enable bits set");
endmodule // tief_enable_bank
`default_nettype wire

// ### core/tief_flag_bank.sv
`default_nettype none
module tief_flag_bank (
   input  wire logic       core_clk,
   input  wire logic       rst,
   tief_reg_if.flags       regs,
   input  wire logic [3:0] match_capture_event,
   input  wire logic [3:0] capture_event,
   input  wire logic [3:0] capture_mode,
   input  wire logic [3:0] channel_capture_value_read,
   input  wire logic       nonrecoverable_fault_1_irq,
   input  wire logic       nonrecoverable_fault_0_irq,
   input  wire logic       recoverable_fault_b_irq,
   input  wire logic       recoverable_fault_a_irq,
   input  wire logic       debug_fault_state_irq,
   input  wire logic       counter_event_irq,
   input  wire logic       retrigger_irq,
   input  wire logic       overflow_irq
);
   tief_pkg::tief_flag_state_t state;
   tief_pkg::tief_flag_state_t next_state;
   logic [tief_pkg::DATA_W-1:0] set_bits;
   logic [tief_pkg::DATA_W-1:0] clr_bits;

   // Sticky flags; a set in the clearing cycle wins
   always_comb begin
      set_bits = tief_pkg::ZERO_WORD;
      set_bits[tief_pkg::MATCH_CAPTURE_LSB +: tief_pkg::MATCH_CAPTURE_N] = match_capture_event | capture_event;
      set_bits[tief_pkg::BIT_NONREC_FAULT_1] = nonrecoverable_fault_1_irq;
      set_bits[tief_pkg::BIT_NONREC_FAULT_0] = nonrecoverable_fault_0_irq;
      set_bits[tief_pkg::BIT_RECOV_FAULT_B]  = recoverable_fault_b_irq;
      set_bits[tief_pkg::BIT_RECOV_FAULT_A]  = recoverable_fault_a_irq;
      set_bits[tief_pkg::BIT_DEBUG_FAULT]    = debug_fault_state_irq;
      set_bits[tief_pkg::BIT_CAPTURE_ERROR]  =
         |(capture_event & state.flag[tief_pkg::MATCH_CAPTURE_LSB +: tief_pkg::MATCH_CAPTURE_N]);
      set_bits[tief_pkg::BIT_COUNTER_EVENT]  = counter_event_irq;
      set_bits[tief_pkg::BIT_RETRIGGER]      = retrigger_irq;
      set_bits[tief_pkg::BIT_OVERFLOW]       = overflow_irq;
      clr_bits = regs.flag_clear_wr ? regs.wr_bits : tief_pkg::ZERO_WORD;
      clr_bits[tief_pkg::MATCH_CAPTURE_LSB +: tief_pkg::MATCH_CAPTURE_N] =
         clr_bits[tief_pkg::MATCH_CAPTURE_LSB +: tief_pkg::MATCH_CAPTURE_N]
         | (channel_capture_value_read & capture_mode);
      next_state = state;
      next_state.flag = ((state.flag & ~clr_bits) | set_bits) & tief_pkg::IMPL_MASK;
      if (rst) begin
         next_state.flag = tief_pkg::RESET_VAL;
      end
   end

   always_ff @(posedge core_clk) begin
      state <= next_state;
   end

   assign regs.flag_q = state.flag;

   a_flag_w1c_clear: assert property (@(posedge core_clk) disable iff (rst)
      (regs.flag_clear_wr && regs.wr_bits[tief_pkg::BIT_OVERFLOW] && !overflow_irq)
      |=> !state.flag[tief_pkg::BIT_OVERFLOW])
      else $error("overflow flag not cleared by write of one");
   a_flag_zero_keeps: assert property (@(posedge core_clk) disable iff (rst)
      (regs.flag_clear_wr && !regs.wr_bits[tief_pkg::BIT_RETRIGGER] && state.flag[tief_pkg::BIT_RETRIGGER])
      |=> state.flag[tief_pkg::BIT_RETRIGGER])
      else $error("retrigger flag lost on write of zero");
   a_capture_lost_error: assert property (@(posedge core_clk) disable iff (rst)
      (|(capture_event & state.flag[tief_pkg::MATCH_CAPTURE_LSB +: tief_pkg::MATCH_CAPTURE_N]))
      |=> state.flag[tief_pkg::BIT_CAPTURE_ERROR])
      else $error("error flag not set on lost capture");
   a_capture_read_clears: assert property (@(posedge core_clk) disable iff (rst)
      (channel_capture_value_read[0] && capture_mode[0] && !match_capture_event[0] && !capture_event[0])
      |=> !state.flag[tief_pkg::MATCH_CAPTURE_LSB])
      else $error("channel 0 flag not cleared by capture read");
   a_fault_bit_place: assert property (@(posedge core_clk) disable iff (rst)
      nonrecoverable_fault_1_irq && recoverable_fault_a_irq
      |=> state.flag[tief_pkg::BIT_NONREC_FAULT_1] && state.flag[tief_pkg::BIT_RECOV_FAULT_A])
      else $error("fault flags at wrong position");
   a_debug_bit_place: assert property (@(posedge core_clk) disable iff (rst)
      debug_fault_state_irq |=> state.flag[tief_pkg::BIT_DEBUG_FAULT])
      else $error("debug fault flag not at bit 11");
endmodule // tief_flag_bank
`default_nettype wire

// ### core/tief_top.sv
`default_nettype none
// Operation
// - Writing one to an enable bit at the enable-clear offset clears that shared interrupt enable.
// - Writing one to an enable bit at the enable-set offset sets that shared enable, channel bits 19:16 included.
// - Writing zero to an enable bit at either enable offset leaves that enable unchanged.
// - Both enable registers read back the same shared enable state, one meaning enabled.
// - Non-recoverable fault 1 and 0 and recoverable fault B and A sit at bits 15, 14, 13 and 12.
// - The debug fault state enable sits at bit 11 and sets and clears like the others.
// - Capture-lost error, counter event, retrigger and overflow sit at bits 3, 2, 1 and 0.
// - Bits 31:20 and 10:4 of enables and flags read zero and ignore writes.
// - Flags and enables are all zero after reset.
// - Writing one to a flag bit clears it, writing zero keeps it.
// - A capture on a channel whose flag is still set raises the error flag.
// - In capture operation a channel flag clears when its capture value is read.
module tief_top (
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   input  wire logic [tief_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [tief_pkg::DATA_W-1:0]   s_axi_wdata,
   input  wire logic [tief_pkg::STRB_W-1:0]   s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [tief_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [tief_pkg::DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [3:0]                    match_capture_event,
   input  wire logic [3:0]                    capture_event,
   input  wire logic [3:0]                    capture_mode,
   input  wire logic [3:0]                    channel_capture_value_read,
   input  wire logic                          nonrecoverable_fault_1_irq,
   input  wire logic                          nonrecoverable_fault_0_irq,
   input  wire logic                          recoverable_fault_b_irq,
   input  wire logic                          recoverable_fault_a_irq,
   input  wire logic                          debug_fault_state_irq,
   input  wire logic                          counter_event_irq,
   input  wire logic                          retrigger_irq,
   input  wire logic                          overflow_irq,
   output logic                               irq
);
   tief_pkg::tief_axi_state_t state;
   tief_pkg::tief_axi_state_t next_state;
   tief_reg_if                regs ();
   logic                      aw_take;
   logic                      w_take;
   logic                      ar_take;
   logic                      do_write;
   logic                      wr_hit;
   logic                      rd_hit;
   logic [tief_pkg::DATA_W-1:0] rd_word;

   // Enable store shared by both enable offsets
   tief_enable_bank u_enable (
      .core_clk (core_clk),
      .rst      (rst),
      .regs     (regs)
   );

   // Sticky event flags
   tief_flag_bank u_flags (
      .core_clk                   (core_clk),
      .rst                        (rst),
      .regs                       (regs),
      .match_capture_event        (match_capture_event),
      .capture_event              (capture_event),
      .capture_mode               (capture_mode),
      .channel_capture_value_read (channel_capture_value_read),
      .nonrecoverable_fault_1_irq (nonrecoverable_fault_1_irq),
      .nonrecoverable_fault_0_irq (nonrecoverable_fault_0_irq),
      .recoverable_fault_b_irq    (recoverable_fault_b_irq),
      .recoverable_fault_a_irq    (recoverable_fault_a_irq),
      .debug_fault_state_irq      (debug_fault_state_irq),
      .counter_event_irq          (counter_event_irq),
      .retrigger_irq              (retrigger_irq),
      .overflow_irq               (overflow_irq)
   );

   // Channel readiness; no new write until the response is taken
   assign s_axi_awready = !state.aw_held && !state.b_valid;
   assign s_axi_wready  = !state.w_held && !state.b_valid;
   assign s_axi_arready = !state.r_valid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign do_write      = state.aw_held && state.w_held && !state.b_valid;

   // Write decode into one-cycle strobes
   assign wr_hit = tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_ENABLE_CLEAR)
                || tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_ENABLE_SET)
                || tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_FLAG);
   assign regs.enable_clear_wr = do_write && tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_ENABLE_CLEAR);
   assign regs.enable_set_wr   = do_write && tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_ENABLE_SET);
   assign regs.flag_clear_wr   = do_write && tief_pkg::addr_is(state.aw_addr, tief_pkg::OFS_FLAG);
   assign regs.wr_bits         = state.w_data & tief_pkg::strb_mask(state.w_strb);

   // Read decode; both enable offsets show the same state
   always_comb begin
      rd_word = tief_pkg::ZERO_WORD;
      rd_hit  = 1'b1;
      if (tief_pkg::addr_is(s_axi_araddr, tief_pkg::OFS_ENABLE_CLEAR)) begin
         rd_word = regs.enable_q & tief_pkg::IMPL_MASK;
      end else if (tief_pkg::addr_is(s_axi_araddr, tief_pkg::OFS_ENABLE_SET)) begin
         rd_word = regs.enable_q & tief_pkg::IMPL_MASK;
      end else if (tief_pkg::addr_is(s_axi_araddr, tief_pkg::OFS_FLAG)) begin
         rd_word = regs.flag_q & tief_pkg::IMPL_MASK;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Bus slave state update
   always_comb begin
      next_state = state;
      if (aw_take) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.b_valid = 1'b1;
         next_state.b_resp  = wr_hit ? tief_pkg::RESP_OKAY : tief_pkg::RESP_SLVERR;
      end
      if (state.b_valid && s_axi_bready) begin
         next_state.b_valid = 1'b0;
      end
      if (state.r_valid && s_axi_rready) begin
         next_state.r_valid = 1'b0;
      end
      if (ar_take) begin
         next_state.r_valid = 1'b1;
         next_state.r_data  = rd_word;
         next_state.r_resp  = rd_hit ? tief_pkg::RESP_OKAY : tief_pkg::RESP_SLVERR;
      end
      if (rst) begin
         next_state = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      state <= next_state;
   end

   // Bus outputs from flops
   assign s_axi_bvalid = state.b_valid;
   assign s_axi_bresp  = state.b_resp;
   assign s_axi_rvalid = state.r_valid;
   assign s_axi_rdata  = state.r_data;
   assign s_axi_rresp  = state.r_resp;

   // Level interrupt from enabled flags
   assign irq = |(regs.flag_q & regs.enable_q);

   a_enclr_clears_bits: assert property (@(posedge core_clk) disable iff (rst)
      regs.enable_clear_wr && !regs.enable_set_wr
      |=> (regs.enable_q & $past(regs.wr_bits)) == tief_pkg::ZERO_WORD)
      else $error("enable not cleared by write of one");
   a_enset_sets_bits: assert property (@(posedge core_clk) disable iff (rst)
      regs.enable_set_wr
      |=> (regs.enable_q & $past(regs.wr_bits) & tief_pkg::IMPL_MASK)
          == ($past(regs.wr_bits) & tief_pkg::IMPL_MASK))
      else $error("enable not set by write of one");
   a_enset_channel_bits: assert property (@(posedge core_clk) disable iff (rst)
      regs.enable_set_wr && regs.wr_bits[tief_pkg::MATCH_CAPTURE_LSB + 3]
      |=> regs.enable_q[tief_pkg::MATCH_CAPTURE_LSB + 3])
      else $error("channel 3 enable not set");
   a_zero_write_keeps: assert property (@(posedge core_clk) disable iff (rst)
      (regs.enable_set_wr || regs.enable_clear_wr)
      |=> (regs.enable_q & ~$past(regs.wr_bits)) == ($past(regs.enable_q) & ~$past(regs.wr_bits)))
      else $error("enable changed by write of zero");
   a_enable_idle_holds: assert property (@(posedge core_clk) disable iff (rst)
      !regs.enable_set_wr && !regs.enable_clear_wr |=> $stable(regs.enable_q))
      else $error("enable changed without a write");
   a_enable_same_read: assert property (@(posedge core_clk) disable iff (rst)
      ar_take && (tief_pkg::addr_is(s_axi_araddr, tief_pkg::OFS_ENABLE_CLEAR)
               || tief_pkg::addr_is(s_axi_araddr, tief_pkg::OFS_ENABLE_SET))
      |=> s_axi_rvalid && s_axi_rdata == $past(regs.enable_q))
      else $error("enable read differs from enable state");
   a_read_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
      s_axi_rvalid |-> (s_axi_rdata & ~tief_pkg::IMPL_MASK) == tief_pkg::ZERO_WORD)
      else $error("reserved bits read nonzero");
   a_reset_clears_all: assert property (@(posedge core_clk)
      $past(rst) |-> regs.enable_q == tief_pkg::RESET_VAL && regs.flag_q == tief_pkg::RESET_VAL
                     && !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("state not zero after reset");
   a_irq_on_enable: assert property (@(posedge core_clk) disable iff (rst)
      regs.enable_set_wr && |(regs.wr_bits & regs.flag_q & tief_pkg::IMPL_MASK) && !regs.flag_clear_wr
      && channel_capture_value_read == 4'h0 |=> irq)
      else $error("irq missing for enabled flag");
   a_irq_needs_enable: assert property (@(posedge core_clk) disable iff (rst)
      regs.enable_q == tief_pkg::ZERO_WORD |-> !irq)
      else $error("irq with all sources disabled");
   a_write_answer_time: assert property (@(posedge core_clk) disable iff (rst)
      do_write |=> s_axi_bvalid ##0 $past(wr_hit) == (s_axi_bresp == tief_pkg::RESP_OKAY))
      else $error("write response late or wrong");
endmodule // tief_top
`default_nettype wire

// ### test/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] VALID = 32'h000f_f80f;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic [3:0]  mce = 4'h0, cap = 4'h0, cmode = 4'h0, cread = 4'h0;
   logic [7:0]  evt = 8'h00;
   logic        irq;
   logic [31:0] en = 32'h0, fl = 32'h0, seed = 32'h0000_3b2d, r;
   logic [33:0] rd_q[$], b_q[$];
   int          miscompares = 0, cmp_count = 0;

   // Clock
   always #10 core_clk = ~core_clk;

   tief_top DUT (
      .core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .match_capture_event(mce), .capture_event(cap), .capture_mode(cmode), .channel_capture_value_read(cread),
      .nonrecoverable_fault_1_irq(evt[7]), .nonrecoverable_fault_0_irq(evt[6]), .recoverable_fault_b_irq(evt[5]),
      .recoverable_fault_a_irq(evt[4]), .debug_fault_state_irq(evt[3]), .counter_event_irq(evt[2]),
      .retrigger_irq(evt[1]), .overflow_irq(evt[0]), .irq(irq)
   );

   // Pseudo-random source
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic end_sim();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_up(input int n);
      if (n >= 50) begin
         miscompares++;
         end_sim();
      end
   endtask

   // Write with both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      logic aw_ok, w_ok, b_ok;
      b_q.push_back({32'h0, er});
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         // Handshakes sampled while settled, acted on at the next edge
         @(negedge core_clk);
         aw_ok = s_axi_awvalid && s_axi_awready === 1'b1;
         w_ok = s_axi_wvalid && s_axi_wready === 1'b1;
         b_ok = s_axi_bvalid === 1'b1;
         @(posedge core_clk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
         if (b_ok) break;
      end
      s_axi_bready <= 1'b0;
      give_up(n);
   endtask

   // Mapped write plus model update
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = d & VALID & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wr(a, d, s, tief_pkg::RESP_OKAY);
      if (a == tief_pkg::OFS_ENABLE_SET) en = en | m;
      if (a == tief_pkg::OFS_ENABLE_CLEAR) en = en & ~m;
      if (a == tief_pkg::OFS_FLAG) fl = fl & ~m;
   endtask

   // Read; expectation noted from the model
   task automatic rd(input logic [7:0] a);
      int n;
      logic ar_ok, r_ok;
      if (a == tief_pkg::OFS_ENABLE_SET || a == tief_pkg::OFS_ENABLE_CLEAR) rd_q.push_back({tief_pkg::RESP_OKAY, en});
      else if (a == tief_pkg::OFS_FLAG) rd_q.push_back({tief_pkg::RESP_OKAY, fl});
      else rd_q.push_back({tief_pkg::RESP_SLVERR, 32'h0});
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ar_ok = s_axi_arvalid && s_axi_arready === 1'b1;
         r_ok = s_axi_rvalid === 1'b1;
         @(posedge core_clk);
         if (ar_ok) s_axi_arvalid <= 1'b0;
         if (r_ok) break;
      end
      s_axi_rready <= 1'b0;
      give_up(n);
   endtask

   task automatic rall();
      rd(tief_pkg::OFS_ENABLE_CLEAR);
      rd(tief_pkg::OFS_ENABLE_SET);
      rd(tief_pkg::OFS_FLAG);
   endtask

   // One cycle of event inputs, then the interrupt line against the model
   task automatic stim(input logic [31:0] v);
      @(posedge core_clk);
      evt <= v[7:0];
      mce <= v[11:8];
      cap <= v[15:12];
      cread <= v[19:16];
      cmode <= v[23:20];
      @(posedge core_clk);
      evt <= 8'h00;
      mce <= 4'h0;
      cap <= 4'h0;
      cread <= 4'h0;
      fl = (fl & ~{12'h0, v[19:16] & v[23:20], 16'h0}) | {12'h0, v[11:8] | v[15:12], v[7:3], 8'h0, v[2:0]}
           | {28'h0, |(v[15:12] & fl[19:16]), 3'h0};
      @(negedge core_clk);
      chk({33'h0, irq}, {33'h0, |(fl & en)});
   endtask

   // Results checked against the oldest note, mid-cycle while settled
   always @(negedge core_clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         chk({32'h0, s_axi_bresp}, b_q.pop_front());
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rall();
      wreg(tief_pkg::OFS_ENABLE_SET, 32'hffff_ffff, 4'hf);
      rall();
      wreg(tief_pkg::OFS_ENABLE_CLEAR, 32'h0, 4'hf);
      rall();
      for (int p = 0; p < 32; p++) begin
         wreg(tief_pkg::OFS_ENABLE_CLEAR, 32'h1 << p, 4'hf);
         rd(tief_pkg::OFS_ENABLE_SET);
         wreg(tief_pkg::OFS_ENABLE_SET, 32'h1 << p, 4'hf);
         rd(tief_pkg::OFS_ENABLE_CLEAR);
      end
      wr(8'h30, 32'hffff_ffff, 4'hf, tief_pkg::RESP_SLVERR);
      rd(8'h30);
      rall();
      for (int i = 0; i < 60; i++) begin
         stim(xs());
         r = xs();
         wreg(r[0] ? tief_pkg::OFS_ENABLE_SET : tief_pkg::OFS_ENABLE_CLEAR, xs() & VALID, r[7:4]);
         if (r[1]) wreg(tief_pkg::OFS_FLAG, xs() & xs() & VALID, r[11:8]);
         stim(32'h0);
         rall();
      end
      // Second reset in mid-run
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      en = 32'h0;
      fl = 32'h0;
      rall();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
